// ==== dmac_core.sv ====
// dmac_core: two-channel byte dma engine with wishbone register slave
`timescale 1ns/100ps
module dmac_core
	import dmac_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic dreq0_i,
	input wire logic dreq1_i,
	output logic bus_hold_o,
	output logic mem_req_o,
	output dmac_mem_cmd_t mem_cmd_o,
	input wire logic mem_ack_i,
	input wire logic [7:0] mem_rdata_i,
	output logic rx_full_irq_suppress_o
);

	// ==========================================================
	// functions
	// ==========================================================
	// next address for a step mode; fixed and i/o keep it
	function automatic logic [19:0] step_addr(input logic [19:0] a, input dmac_step_t s);
		case (s)
			STEP_INC: step_addr = a + 20'h00001;
			STEP_DEC: step_addr = a - 20'h00001;
			default: step_addr = a;
		endcase
	endfunction

	// reserved combination: destination fixed or i/o with source fixed or i/o
	function automatic logic mode_reserved(input logic [5:0] m);
		mode_reserved = m[MODE_DEST_HI] && m[MODE_SRC_HI];
	endfunction

	// ==========================================================
	// declarations
	// ==========================================================
	typedef enum logic [4:0] {
		EN_IDLE = 5'b00001,
		EN_RUN = 5'b00010,
		EN_READ = 5'b00100,
		EN_WRITE = 5'b01000,
		EN_GIVE = 5'b10000
	} dmac_state_t;

	dmac_state_t state_r; // engine state
	logic ack_r; // wishbone acknowledge
	logic [31:0] rdata_r; // registered read data
	logic [15:0] cnt0_r; // ch0 byte counter
	logic [15:0] cnt1_r; // ch1 byte counter
	logic [15:0] rd_left_r; // reads still to issue
	logic [19:0] ch0_source_address_r; // ch0 source address
	logic [19:0] ch0_dest_address_r; // ch0 destination address
	logic [19:0] mar1_r; // ch1 memory address
	logic [7:0] ioar1_r; // ch1 fixed i/o address
	logic [5:0] mode0_r; // ch0 mode bits, start bit not stored
	logic dir1_r; // ch1 direction
	logic [1:0] busy_r; // channel running
	logic [1:0] done_r; // sticky end flags
	logic mode_err_r; // sticky reserved-mode flag
	logic act_r; // channel owning the engine
	dmac_mem_cmd_t cmd_r; // command on the side bus
	logic [7:0] idx; // word index of the bus access
	logic wr_en; // write takes effect this edge
	logic rd_en; // read data captured this edge
	logic wr_b0; // byte lane 0 written
	logic start0; // software start of ch0
	logic start1; // software start of ch1
	dmac_cfg_t cfg0; // decoded ch0 behaviour
	dmac_cfg_t cfg1; // decoded ch1 behaviour
	dmac_cfg_t cfg; // active channel behaviour
	logic [19:0] src_addr; // active source address
	logic [19:0] dst_addr; // active destination address
	logic [15:0] cnt_act; // active counter
	logic dreq_act; // active request input
	logic src_ok; // read side may go
	logic dst_ok; // write side may go
	logic rd_done; // read acknowledged
	logic wr_done; // write acknowledged
	logic finish; // operation complete
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;

	// ==========================================================
	// wishbone slave
	// ==========================================================
	assign idx = wb_adr_i[9:2];
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
	assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
	assign wr_b0 = wr_en && wb_sel_i[0];
	assign start0 = wr_b0 && (idx == IDX_CH0_MODE) && wb_dat_i[MODE_START] && !busy_r[0];
	assign start1 = wr_b0 && (idx == IDX_CH1_CTRL) && wb_dat_i[CH1_START] && !busy_r[1];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
		end
	end

	// read mux; unmapped indices and upper bits read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= '0;
		end else if (rd_en) begin
			rdata_r <= '0;
			case (idx)
				IDX_CH0_COUNT_LOW: rdata_r[7:0] <= cnt0_r[7:0];
				IDX_CH0_COUNT_HIGH: rdata_r[7:0] <= cnt0_r[15:8];
				IDX_CH1_COUNT_LOW: rdata_r[7:0] <= cnt1_r[7:0];
				IDX_CH1_COUNT_HIGH: rdata_r[7:0] <= cnt1_r[15:8];
				IDX_CH1_MEM_ADDR_LOW: rdata_r[7:0] <= mar1_r[7:0];
				IDX_CH1_MEM_ADDR_HIGH: rdata_r[7:0] <= mar1_r[15:8];
				IDX_CH1_MEM_ADDR_BANK: rdata_r[7:0] <= {4'h0, mar1_r[19:16]};
				IDX_CH0_SRC_LOW: rdata_r[7:0] <= ch0_source_address_r[7:0];
				IDX_CH0_SRC_HIGH: rdata_r[7:0] <= ch0_source_address_r[15:8];
				IDX_CH0_SRC_BANK: rdata_r[7:0] <= {4'h0, ch0_source_address_r[19:16]};
				IDX_CH0_DST_LOW: rdata_r[7:0] <= ch0_dest_address_r[7:0];
				IDX_CH0_DST_HIGH: rdata_r[7:0] <= ch0_dest_address_r[15:8];
				IDX_CH0_DST_BANK: rdata_r[7:0] <= {4'h0, ch0_dest_address_r[19:16]};
				IDX_CH0_MODE: rdata_r[7:0] <= {2'h0, mode0_r[5:1], 1'b0};
				IDX_CH1_CTRL: rdata_r[7:0] <= {6'h00, dir1_r, 1'b0};
				IDX_CH1_IO_ADDR: rdata_r[7:0] <= ioar1_r;
				IDX_STATUS: rdata_r[7:0] <= {3'h0, mode_err_r, done_r, busy_r};
				default: rdata_r[7:0] <= BUS_ZERO;
			endcase
		end
	end

	// ==========================================================
	// configuration registers
	// ==========================================================
	// ch0 mode; reset gives cycle steal timing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode0_r <= CH0_MODE_RESET;
		end else if (wr_b0 && (idx == IDX_CH0_MODE) && !busy_r[0]) begin
			mode0_r <= {wb_dat_i[5:1], 1'b0};
		end
	end

	// ch1 direction and i/o address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir1_r <= CH1_DIR_RESET;
			ioar1_r <= BUS_ZERO;
		end else if (wr_b0 && !busy_r[1]) begin
			if (idx == IDX_CH1_CTRL) begin
				dir1_r <= wb_dat_i[CH1_DIR];
			end
			if (idx == IDX_CH1_IO_ADDR) begin
				ioar1_r <= wb_dat_i[7:0];
			end
		end
	end

	// ==========================================================
	// mode decode
	// ==========================================================
	// ch0: two bits each side, i/o to i/o is not offered
	always_comb begin
		cfg0.dst_step = dmac_step_t'(mode0_r[MODE_DEST_HI:MODE_DEST_LO]);
		cfg0.src_step = dmac_step_t'(mode0_r[MODE_SRC_HI:MODE_SRC_LO]);
		cfg0.dst_io = (cfg0.dst_step == STEP_IO);
		cfg0.src_io = (cfg0.src_step == STEP_IO);
		// timing bit counts only when neither side is i/o
		cfg0.burst = mode0_r[MODE_MEM_TIMING] && !cfg0.src_io && !cfg0.dst_io;
	end

	// ch1: memory side steps up from its address, i/o side fixed
	always_comb begin
		cfg1.src_io = dir1_r;
		cfg1.dst_io = !dir1_r;
		cfg1.src_step = dir1_r ? STEP_IO : STEP_INC;
		cfg1.dst_step = dir1_r ? STEP_INC : STEP_IO;
		cfg1.burst = 1'b0;
	end

	assign cfg = act_r ? cfg1 : cfg0;
	assign src_addr = act_r ? (dir1_r ? {12'h000, ioar1_r} : mar1_r) : ch0_source_address_r;
	assign dst_addr = act_r ? (dir1_r ? mar1_r : {12'h000, ioar1_r}) : ch0_dest_address_r;
	assign cnt_act = act_r ? cnt1_r : cnt0_r;
	assign dreq_act = act_r ? dreq1_i : dreq0_i;
	// request paces only the i/o side; memory-to-memory runs free
	assign src_ok = !cfg.src_io || dreq_act;
	assign dst_ok = !cfg.dst_io || dreq_act;

	// serial ch1 feeds ch0, so its rx_full_flag must not interrupt
	assign rx_full_irq_suppress_o = cfg0.src_io && (ch0_source_address_r[17:16] == 2'b10);

	// ==========================================================
	// byte counters and addresses
	// ==========================================================
	assign rd_done = (state_r == EN_READ) && mem_ack_i;
	assign wr_done = (state_r == EN_WRITE) && mem_ack_i;

	// counters: no reset, loaded by software, minus one per byte written
	always_ff @(posedge clk_i) begin
		if (wr_done && !act_r) begin
			cnt0_r <= cnt0_r - 16'h0001;
		end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_COUNT_LOW)) begin
			cnt0_r[7:0] <= wb_dat_i[7:0];
		end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_COUNT_HIGH)) begin
			cnt0_r[15:8] <= wb_dat_i[7:0];
		end
	end

	// ch1 counter, same behaviour, also unreset
	always_ff @(posedge clk_i) begin
		if (wr_done && act_r) begin
			cnt1_r <= cnt1_r - 16'h0001;
		end else if (wr_b0 && !busy_r[1] && (idx == IDX_CH1_COUNT_LOW)) begin
			cnt1_r[7:0] <= wb_dat_i[7:0];
		end else if (wr_b0 && !busy_r[1] && (idx == IDX_CH1_COUNT_HIGH)) begin
			cnt1_r[15:8] <= wb_dat_i[7:0];
		end
	end
	// the counters above deliberately have no reset branch

	// ch0 addresses step after each acknowledged access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ch0_source_address_r <= '0;
			ch0_dest_address_r <= '0;
		end else begin
			if (rd_done && !act_r) begin
				ch0_source_address_r <= step_addr(ch0_source_address_r, cfg0.src_step);
			end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_SRC_LOW)) begin
				ch0_source_address_r[7:0] <= wb_dat_i[7:0];
			end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_SRC_HIGH)) begin
				ch0_source_address_r[15:8] <= wb_dat_i[7:0];
			end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_SRC_BANK)) begin
				ch0_source_address_r[19:16] <= wb_dat_i[3:0];
			end
			if (wr_done && !act_r) begin
				ch0_dest_address_r <= step_addr(ch0_dest_address_r, cfg0.dst_step);
			end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_DST_LOW)) begin
				ch0_dest_address_r[7:0] <= wb_dat_i[7:0];
			end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_DST_HIGH)) begin
				ch0_dest_address_r[15:8] <= wb_dat_i[7:0];
			end else if (wr_b0 && !busy_r[0] && (idx == IDX_CH0_DST_BANK)) begin
				ch0_dest_address_r[19:16] <= wb_dat_i[3:0];
			end
		end
	end

	// ch1 memory address, source or destination by direction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mar1_r <= '0;
		end else if (act_r && ((rd_done && !dir1_r) || (wr_done && dir1_r))) begin
			mar1_r <= step_addr(mar1_r, STEP_INC);
		end else if (wr_b0 && !busy_r[1] && (idx == IDX_CH1_MEM_ADDR_LOW)) begin
			mar1_r[7:0] <= wb_dat_i[7:0];
		end else if (wr_b0 && !busy_r[1] && (idx == IDX_CH1_MEM_ADDR_HIGH)) begin
			mar1_r[15:8] <= wb_dat_i[7:0];
		end else if (wr_b0 && !busy_r[1] && (idx == IDX_CH1_MEM_ADDR_BANK)) begin
			mar1_r[19:16] <= wb_dat_i[3:0];
		end
	end

	// ==========================================================
	// status flags
	// ==========================================================
	// operation over when all bytes written and nothing in flight
	assign finish = (state_r == EN_RUN) && (cnt_act == 16'h0000) && (rd_left_r == 16'h0000) && !fifo_out_valid;

	// busy set by start, cleared at the end; done set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_r <= 2'b00;
			done_r <= 2'b00;
			mode_err_r <= 1'b0;
		end else begin
			if (start0 && !mode_reserved(wb_dat_i[5:0])) begin
				busy_r[0] <= 1'b1;
			end else if (finish && !act_r) begin
				busy_r[0] <= 1'b0;
			end
			if (start1) begin
				busy_r[1] <= 1'b1;
			end else if (finish && act_r) begin
				busy_r[1] <= 1'b0;
			end
			if (finish) begin
				done_r[act_r] <= 1'b1;
			end else if (wr_b0 && (idx == IDX_STATUS)) begin
				done_r <= done_r & ~wb_dat_i[ST_DONE1:ST_DONE0];
			end
			if (start0 && mode_reserved(wb_dat_i[5:0])) begin
				mode_err_r <= 1'b1;
			end else if (wr_b0 && (idx == IDX_STATUS) && wb_dat_i[ST_MODE_ERR]) begin
				mode_err_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// transfer engine
	// ==========================================================
	// one read or write at a time on the side bus; fifo decouples them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= EN_IDLE;
			act_r <= 1'b0;
			rd_left_r <= '0;
			cmd_r <= '0;
		end else begin
			case (state_r)
				EN_IDLE: begin
					// channel 0 wins when both are pending
					if (busy_r[0]) begin
						act_r <= 1'b0;
						rd_left_r <= cnt0_r;
						state_r <= EN_RUN;
					end else if (busy_r[1]) begin
						act_r <= 1'b1;
						rd_left_r <= cnt1_r;
						state_r <= EN_RUN;
					end
				end
				EN_RUN: begin
					if (finish) begin
						state_r <= EN_IDLE;
					end else if (fifo_out_valid && dst_ok) begin
						cmd_r <= '{io: cfg.dst_io, we: 1'b1, addr: dst_addr, wdata: fifo_out_data};
						state_r <= EN_WRITE;
					end else if ((rd_left_r != 16'h0000) && fifo_in_ready && src_ok) begin
						cmd_r <= '{io: cfg.src_io, we: 1'b0, addr: src_addr, wdata: 8'h00};
						state_r <= EN_READ;
					end
				end
				EN_READ: begin
					if (mem_ack_i) begin
						rd_left_r <= rd_left_r - 16'h0001;
						state_r <= EN_RUN;
					end
				end
				EN_WRITE: begin
					if (mem_ack_i) begin
						// steal mode hands one cycle back per byte
						state_r <= cfg.burst ? EN_RUN : EN_GIVE;
					end
				end
				EN_GIVE: begin
					state_r <= EN_RUN;
				end
				default: begin
					state_r <= EN_IDLE;
				end
			endcase
		end
	end

	// bus held during accesses, and between them in burst mode
	assign bus_hold_o = (state_r == EN_READ) || (state_r == EN_WRITE)
		|| ((state_r == EN_RUN) && cfg.burst && !finish);
	assign mem_req_o = (state_r == EN_READ) || (state_r == EN_WRITE);
	assign mem_cmd_o = cmd_r;

	// ==========================================================
	// data buffer
	// ==========================================================
	dmac_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(rd_done),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem_rdata_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(wr_done),
		.out_data_o(fifo_out_data)
	);

endmodule

// ==== dmac_pkg.sv ====
// dmac_pkg: register indices, field positions, reset values and carrier types for the dma block
package dmac_pkg;

	// ==========================================================
	// register word indices (byte address = 4 * index)
	// ==========================================================
	localparam logic [7:0] IDX_CH0_COUNT_LOW = 8'h26; // ch0 byte counter, low byte
	localparam logic [7:0] IDX_CH0_COUNT_HIGH = 8'h27; // ch0 byte counter, high byte
	localparam logic [7:0] IDX_CH1_MEM_ADDR_LOW = 8'h28; // ch1 memory address, bits 7:0
	localparam logic [7:0] IDX_CH1_MEM_ADDR_HIGH = 8'h29; // ch1 memory address, bits 15:8
	localparam logic [7:0] IDX_CH1_MEM_ADDR_BANK = 8'h2a; // ch1 memory address, bits 19:16
	localparam logic [7:0] IDX_CH1_COUNT_LOW = 8'h2e; // ch1 byte counter, low byte
	localparam logic [7:0] IDX_CH1_COUNT_HIGH = 8'h2f; // ch1 byte counter, high byte
	localparam logic [7:0] IDX_CH0_SRC_LOW = 8'h20; // ch0 source address, bits 7:0
	localparam logic [7:0] IDX_CH0_SRC_HIGH = 8'h21; // ch0 source address, bits 15:8
	localparam logic [7:0] IDX_CH0_SRC_BANK = 8'h22; // ch0 source address, bits 19:16
	localparam logic [7:0] IDX_CH0_DST_LOW = 8'h23; // ch0 destination address, bits 7:0
	localparam logic [7:0] IDX_CH0_DST_HIGH = 8'h24; // ch0 destination address, bits 15:8
	localparam logic [7:0] IDX_CH0_DST_BANK = 8'h25; // ch0 destination address, bits 19:16
	localparam logic [7:0] IDX_CH0_MODE = 8'h30; // ch0 transfer mode and start
	localparam logic [7:0] IDX_CH1_CTRL = 8'h31; // ch1 direction and start
	localparam logic [7:0] IDX_CH1_IO_ADDR = 8'h32; // ch1 fixed i/o address
	localparam logic [7:0] IDX_STATUS = 8'h33; // busy, done and error flags

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int MODE_DEST_HI = 5; // dest_mode_hi
	localparam int MODE_DEST_LO = 4; // dest_mode_lo
	localparam int MODE_SRC_HI = 3; // src_mode_hi
	localparam int MODE_SRC_LO = 2; // src_mode_lo
	localparam int MODE_MEM_TIMING = 1; // mem_timing_select: 1 burst, 0 cycle steal
	localparam int MODE_START = 0; // write 1 to start channel 0
	localparam int CH1_DIR = 1; // 0 memory to i/o, 1 i/o to memory
	localparam int CH1_START = 0; // write 1 to start channel 1
	localparam int ST_BUSY0 = 0; // channel 0 running
	localparam int ST_BUSY1 = 1; // channel 1 running
	localparam int ST_DONE0 = 2; // channel 0 finished, write 1 to clear
	localparam int ST_DONE1 = 3; // channel 1 finished, write 1 to clear
	localparam int ST_MODE_ERR = 4; // reserved mode was started, write 1 to clear

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [5:0] CH0_MODE_RESET = 6'h00; // cycle steal, mem inc to mem inc
	localparam logic CH1_DIR_RESET = 1'b0;
	localparam logic [7:0] BUS_ZERO = 8'h00; // unmapped and reserved bits read as zero
	localparam int FIFO_DEPTH = 16; // bytes buffered between read and write phases
	localparam int FIFO_WIDTH = 8;

	// ==========================================================
	// types
	// ==========================================================
	typedef enum logic [1:0] {
		STEP_INC = 2'b00,
		STEP_DEC = 2'b01,
		STEP_FIXED = 2'b10,
		STEP_IO = 2'b11
	} dmac_step_t;

	// one side-bus access issued by the engine
	typedef struct packed {
		logic io; // 1 i/o space, 0 memory space
		logic we; // 1 write, 0 read
		logic [19:0] addr;
		logic [7:0] wdata;
	} dmac_mem_cmd_t;

	// decoded behaviour of the active channel
	typedef struct packed {
		logic src_io;
		logic dst_io;
		dmac_step_t src_step;
		dmac_step_t dst_step;
		logic burst;
	} dmac_cfg_t;

endpackage

// ==== dmac_fifo.sv ====
// dmac_fifo: parameterised valid/ready fifo between the read and write phases
`timescale 1ns/100ps
module dmac_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
	logic [AW-1:0] wr_ptr_r; // next slot to fill
	logic [AW-1:0] rd_ptr_r; // oldest word
	logic [AW:0] fill_r; // words held
	logic push; // accepted write
	logic pop; // accepted read

	// honest flags from the fill count
	assign in_ready_o = (fill_r != (AW+1)'(DEPTH));
	assign out_valid_o = (fill_r != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_ready_i && out_valid_o;
	assign out_data_o = mem_r[rd_ptr_r];

	// storage write, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
			end
			// both at once leaves the level unchanged
			if (push && !pop) begin
				fill_r <= fill_r + (AW+1)'(1);
			end else if (pop && !push) begin
				fill_r <= fill_r - (AW+1)'(1);
			end
		end
	end
endmodule

// ==== dmac_core_asserts.sv ====
// dmac_core_asserts: port-level checks of the dma core, bound to its top
`timescale 1ns/100ps
// ==========================================================
// checker
module dmac_core_chk
	import dmac_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic dreq0_i,
	input wire logic dreq1_i,
	input wire logic bus_hold_o,
	input wire logic mem_req_o,
	input wire dmac_mem_cmd_t mem_cmd_o,
	input wire logic mem_ack_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack unasked");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
	cmd_stable_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_cmd_o)) else $error("cmd moved");
	req_drop_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o) else $error("req held");
	io_paced_a: assert property ($rose(mem_req_o) && mem_cmd_o.io |-> $past(dreq0_i) || $past(dreq1_i)) else $error("io unpaced");
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !mem_req_o && !bus_hold_o) else $error("reset busy");
endmodule

bind dmac_core dmac_core_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .dreq0_i, .dreq1_i,
	.bus_hold_o, .mem_req_o, .mem_cmd_o, .mem_ack_i);

// ==== dmac_mem_model.sv ====
// dmac_mem_model: byte memory and i/o space answering the engine's side bus
`timescale 1ns/100ps
// ==========================================================
// partner model
module dmac_mem_model
	import dmac_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic mem_req_i,
	input wire dmac_mem_cmd_t mem_cmd_i,
	output logic mem_ack_o,
	output logic [7:0] mem_rdata_o
);
	logic [7:0] mem_r [256]; // i/o and memory share one small space
	logic [1:0] wait_r; // wait states before answering when slow
	initial foreach (mem_r[i]) mem_r[i] = 8'(i) ^ 8'h5a;
	// answer one access; read data is scrambled outside the ack cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			mem_ack_o <= 1'b0;
			wait_r <= 2'h0;
			mem_rdata_o <= 8'h00;
		end else if (mem_req_i && !mem_ack_o && (wait_r == 2'h3 || !slow_i)) begin
			mem_ack_o <= 1'b1;
			mem_rdata_o <= mem_r[mem_cmd_i.addr[7:0]];
			if (mem_cmd_i.we) mem_r[mem_cmd_i.addr[7:0]] <= mem_cmd_i.wdata;
			wait_r <= 2'h0;
		end else begin
			mem_ack_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
			wait_r <= mem_req_i ? wait_r + 2'h1 : 2'h0;
		end
	end
endmodule

// ==== testbench.sv ====
// testbench: scenario tasks for the dma core against the memory model
`timescale 1ns/100ps
module testbench;
	import dmac_pkg::*;
	// ==========================================================
	// signals
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, dreq0 = 1, dreq1 = 1, slow = 0;
	logic [9:0] adr = '0;
	logic [31:0] dat = '0, rd, wdo;
	logic ack, hold, req, mack, sup, hold_q = 0;
	logic [7:0] mrd;
	dmac_mem_cmd_t cmd, lr, lw;
	int n_fail = 0, compares = 0, wrs = 0, falls = 0;
	dmac_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .dreq0_i(dreq0), .dreq1_i(dreq1),
		.bus_hold_o(hold), .mem_req_o(req), .mem_cmd_o(cmd), .mem_ack_i(mack), .mem_rdata_i(mrd),
		.rx_full_irq_suppress_o(sup));
	dmac_mem_model pm (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mem_req_i(req), .mem_cmd_i(cmd),
		.mem_ack_o(mack), .mem_rdata_o(mrd));
	initial forever #25 clk_i = ~clk_i;
	// ==========================================================
	// monitor: hold releases, completed writes, last accesses
	always @(posedge clk_i) begin
		hold_q <= hold;
		if (hold_q && !hold) falls++;
		if (req && mack && cmd.we) begin wrs++; lw = cmd; end
		if (req && mack && !cmd.we) lr = cmd;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end
	endtask
	// one classic wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
		cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; dat <= {24'h0, d};
		// no local limit: only the watchdog ends a wait for ack
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = wdo;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk_i);
	endtask
	task automatic idle;
		// poll status until both busy bits clear; a hang ends at the watchdog
		do wb(0, 8'h33, 0); while (rd[1:0] !== 2'b00);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs;
		logic [7:0] a [7] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2e, 8'h2f};
		wb(0, 8'h30, 0); chk("mode reset", 0, rd);
		foreach (a[k]) wb(1, a[k], 8'h03 + 8'(k));
		foreach (a[k]) begin wb(0, a[k], 0); chk("reg", 8'h03 + k, rd); end
		wb(0, 8'h3f, 0); chk("unmapped", 0, rd);
	endtask
	task automatic t_modes;
		int ds, ss;
		for (int m = 0; m < 16; m++) begin
			wrs = 0;
			slow <= m[0];
			wb(1, 8'h20, 8'h40); wb(1, 8'h23, 8'h90);
			wb(1, 8'h26, 8'h02); wb(1, 8'h27, 8'h00);
			wb(1, 8'h30, {2'b00, m[3:0], 2'b11});
			idle;
			chk("bytes", (m[3] && m[1]) ? 0 : 2, wrs);
			if (m[3] && m[1]) begin
				chk("reserved", 1, rd[4]);
				wb(1, 8'h33, 8'h10);
			end else begin
				ds = (m[3:2] == 0) ? 1 : (m[3:2] == 1) ? -1 : 0;
				ss = (m[1:0] == 0) ? 1 : (m[1:0] == 1) ? -1 : 0;
				chk("rd addr", 8'h40 + ss, lr.addr[7:0]);
				chk("wr addr", 8'h90 + ds, lw.addr[7:0]);
				chk("io kind", {m[3] & m[2], m[1] & m[0]}, {lw.io, lr.io});
				wb(0, 8'h26, 0); chk("count end", 0, rd);
			end
		end
		slow <= 0;
	endtask
	task automatic t_timing(input logic b);
		wb(1, 8'h20, 8'h20); wb(1, 8'h23, 8'h60); wb(1, 8'h26, 8'h04);
		falls = 0;
		wb(1, 8'h30, {6'h0, b, 1'b1});
		idle;
		chk("hold gaps", 1, b ? falls == 1 : falls >= 4);
		for (int i = 0; i < 4; i++) chk("copy", 8'(8'h20 + i) ^ 8'h5a, pm.mem_r[8'h60 + i]);
	endtask
	task automatic t_ch1;
		wrs = 0;
		wb(1, 8'h28, 8'h30); wb(1, 8'h29, 8'h00); wb(1, 8'h2a, 8'h00); wb(1, 8'h32, 8'h05);
		wb(1, 8'h2e, 8'h02); wb(1, 8'h2f, 8'h00);
		wb(1, 8'h31, 8'h01);
		idle;
		chk("ch1 bytes", 2, wrs);
		chk("ch1 src", 21'h000031, {lr.io, lr.addr});
		chk("ch1 dst io", 1, lw.io);
	endtask
	task automatic t_pace;
		wrs = 0;
		falls = 0;
		// both requests low so the pacing check cannot lean on the other channel
		dreq0 <= 0; dreq1 <= 0;
		wb(1, 8'h26, 8'h01); wb(1, 8'h30, 8'h0f);
		repeat (20) @(posedge clk_i);
		chk("no request", 0, wrs);
		dreq0 <= 1; dreq1 <= 1;
		idle;
		chk("paced", 1, wrs);
		chk("timing ignored", 1, falls >= 2);
	endtask
	task automatic t_supp;
		wb(1, 8'h22, 8'h02); wb(1, 8'h30, 8'h0c);
		chk("rx supp", 1, sup);
		wb(1, 8'h22, 8'h01);
		chk("rx supp", 0, sup);
	endtask
	// ==========================================================
	// verdict, main sequence and watchdog
	task automatic tally_and_finish;
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_regs;
		t_modes;
		t_timing(1);
		t_timing(0);
		t_ch1;
		t_pace;
		t_supp;
		tally_and_finish;
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		n_fail++;
		tally_and_finish;
	end
endmodule
